// *** axil_reg_slave.sv ***
// single-beat axi4-lite slave turning bus traffic into register strobes
`timescale 1ns/100ps
`default_nettype none
module axil_reg_slave
  import intx_msi_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // write channels
  input  wire logic [31:0] s_axi_ctl_awaddr,
  input  wire logic        s_axi_ctl_awvalid,
  output logic             s_axi_ctl_awready,
  input  wire logic [31:0] s_axi_ctl_wdata,
  input  wire logic [3:0]  s_axi_ctl_wstrb,
  input  wire logic        s_axi_ctl_wvalid,
  output logic             s_axi_ctl_wready,
  output logic [1:0]       s_axi_ctl_bresp,
  output logic             s_axi_ctl_bvalid,
  input  wire logic        s_axi_ctl_bready,
  // read channels
  input  wire logic [31:0] s_axi_ctl_araddr,
  input  wire logic        s_axi_ctl_arvalid,
  output logic             s_axi_ctl_arready,
  output logic [31:0]      s_axi_ctl_rdata,
  output logic [1:0]       s_axi_ctl_rresp,
  output logic             s_axi_ctl_rvalid,
  input  wire logic        s_axi_ctl_rready,
  // register side
  reg_access_if.bus        regs
);
  logic        aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [31:0] awaddr_reg, awaddr_next, wdata_reg, wdata_next;
  logic [3:0]  wstrb_reg, wstrb_next;
  logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        aw_take, w_take, aw_have, w_have;

  // address and data are taken in either order; both are held off while
  // a response is pending, so at most one write is ever in flight
  assign s_axi_ctl_awready = !aw_got_reg && !bvalid_reg;
  assign s_axi_ctl_wready  = !w_got_reg && !bvalid_reg;
  assign s_axi_ctl_arready = !rvalid_reg;
  assign aw_take = s_axi_ctl_awvalid && s_axi_ctl_awready;
  assign w_take  = s_axi_ctl_wvalid && s_axi_ctl_wready;
  assign aw_have = aw_got_reg || aw_take;
  assign w_have  = w_got_reg || w_take;

  assign regs.wr_en   = aw_have && w_have && !bvalid_reg;
  assign regs.wr_addr = aw_got_reg ? awaddr_reg : s_axi_ctl_awaddr;
  assign regs.wr_data = w_got_reg ? wdata_reg : s_axi_ctl_wdata;
  assign regs.wr_strb = w_got_reg ? wstrb_reg : s_axi_ctl_wstrb;
  assign regs.rd_en   = s_axi_ctl_arvalid && s_axi_ctl_arready;
  assign regs.rd_addr = s_axi_ctl_araddr;

  always_comb begin
    aw_got_next = aw_got_reg;
    w_got_next  = w_got_reg;
    awaddr_next = aw_take ? s_axi_ctl_awaddr : awaddr_reg;
    wdata_next  = w_take ? s_axi_ctl_wdata : wdata_reg;
    wstrb_next  = w_take ? s_axi_ctl_wstrb : wstrb_reg;
    bvalid_next = bvalid_reg && !s_axi_ctl_bready;
    bresp_next  = bresp_reg;
    rvalid_next = rvalid_reg && !s_axi_ctl_rready;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    if (regs.wr_en) begin
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = regs.wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else begin
      aw_got_next = aw_have;
      w_got_next  = w_have;
    end
    if (regs.rd_en) begin
      rvalid_next = 1'b1;
      rdata_next  = regs.rd_ok ? regs.rd_data : 32'h0000_0000;
      rresp_next  = regs.rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      awaddr_reg <= 32'h0000_0000;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else begin
      aw_got_reg <= aw_got_next;
      w_got_reg  <= w_got_next;
      awaddr_reg <= awaddr_next;
      wdata_reg  <= wdata_next;
      wstrb_reg  <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg  <= rresp_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign s_axi_ctl_bvalid = bvalid_reg;
  assign s_axi_ctl_bresp  = bresp_reg;
  assign s_axi_ctl_rvalid = rvalid_reg;
  assign s_axi_ctl_rresp  = rresp_reg;
  assign s_axi_ctl_rdata  = rdata_reg;

endmodule : axil_reg_slave
`default_nettype wire

// *** intx_msi_pkg.sv ***
// constants shared by the interrupt request port and its register slave
package intx_msi_pkg;

  // register bus
  localparam int unsigned  AXI_AW          = 32;
  localparam int unsigned  AXI_DW          = 32;
  localparam logic [1:0]   RESP_OKAY       = 2'h0;
  localparam logic [1:0]   RESP_SLVERR     = 2'h2;

  // register byte offsets
  localparam logic [31:0]  REG_CTRL        = 32'h0000_0000;
  localparam logic [31:0]  REG_STATUS      = 32'h0000_0004;
  localparam logic [31:0]  REG_IRQ_STATUS  = 32'h0000_0008;
  localparam logic [31:0]  REG_IRQ_MASK    = 32'h0000_000C;
  localparam logic [31:0]  REG_COUNT       = 32'h0000_0010;
  localparam logic [31:0]  REG_LAST        = 32'h0000_0014;
  localparam logic [31:0]  REG_SW_REQ      = 32'h0000_0018;

  // field positions
  localparam int unsigned  CTRL_EN_BIT     = 0;
  localparam int unsigned  STAT_MSI_BIT    = 0;
  localparam int unsigned  STAT_WIDTH_LSB  = 1;
  localparam int unsigned  STAT_BUSY_BIT   = 4;
  localparam int unsigned  IRQ_GRANT_BIT   = 0;
  localparam int unsigned  IRQ_DROP_BIT    = 1;
  localparam int unsigned  LAST_MODE_BIT   = 8;
  localparam int unsigned  CNT_LEG_LSB     = 16;

  // widths
  localparam int unsigned  IRQ_W           = 2;
  localparam int unsigned  VEC_W           = 5;
  localparam int unsigned  VWID_W          = 3;
  localparam int unsigned  PIN_W           = 2;
  localparam int unsigned  CNT_W           = 16;

  // reset values
  localparam logic         CTRL_EN_RST     = 1'h1;
  localparam logic [1:0]   IRQ_MASK_RST    = 2'h0;

  // legacy pin codes: 0 = first pin
  localparam logic [1:0]   INTX_PIN_DEF    = 2'h0;

endpackage : intx_msi_pkg

// *** intx_msi_request_port.sv ***
// interrupt request port: legacy or message interrupt toward the link core
`timescale 1ns/100ps
`default_nettype none
module intx_msi_request_port
  import intx_msi_pkg::*;
#(
  parameter logic [PIN_W-1:0] INTX_PIN = INTX_PIN_DEF
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // axi4-lite write channels
  input  wire logic [31:0]       s_axi_ctl_awaddr,
  input  wire logic              s_axi_ctl_awvalid,
  output logic                   s_axi_ctl_awready,
  input  wire logic [31:0]       s_axi_ctl_wdata,
  input  wire logic [3:0]        s_axi_ctl_wstrb,
  input  wire logic              s_axi_ctl_wvalid,
  output logic                   s_axi_ctl_wready,
  output logic [1:0]             s_axi_ctl_bresp,
  output logic                   s_axi_ctl_bvalid,
  input  wire logic              s_axi_ctl_bready,
  // axi4-lite read channels
  input  wire logic [31:0]       s_axi_ctl_araddr,
  input  wire logic              s_axi_ctl_arvalid,
  output logic                   s_axi_ctl_arready,
  output logic [31:0]            s_axi_ctl_rdata,
  output logic [1:0]             s_axi_ctl_rresp,
  output logic                   s_axi_ctl_rvalid,
  input  wire logic              s_axi_ctl_rready,
  // user request port
  input  wire logic              intx_msi_request,
  input  wire logic [VEC_W-1:0]  msi_vector_num,
  output logic                   intx_msi_grant,
  output logic                   msi_enable,
  output logic [VWID_W-1:0]      msi_vector_width,
  // link core side
  input  wire logic              core_msi_enabled,
  input  wire logic [VWID_W-1:0] core_msi_vec_alloc,
  output logic                   core_int_valid,
  output logic                   core_int_is_msi,
  output logic [VEC_W-1:0]       core_int_vector,
  output logic [PIN_W-1:0]       core_int_pin,
  input  wire logic              core_int_accept,
  // software interrupt
  output logic                   irq
);

  typedef enum logic [0:0] {ST_IDLE, ST_WAIT} send_state_t;

  reg_access_if regs ();

  send_state_t             state_reg, state_next;
  logic                    ctrl_en_reg, ctrl_en_next;
  logic                    msi_en_reg, msi_en_next;
  logic [VWID_W-1:0]       vwid_reg, vwid_next;
  logic                    mode_msi_reg, mode_msi_next;
  logic [VEC_W-1:0]        vec_reg, vec_next;
  logic                    grant_reg, grant_next;
  logic                    sw_req_reg, sw_req_next;
  logic [VEC_W-1:0]        sw_vec_reg, sw_vec_next;
  logic [CNT_W-1:0]        msi_cnt_reg, msi_cnt_next;
  logic [CNT_W-1:0]        leg_cnt_reg, leg_cnt_next;

  logic                    req_any;
  logic [VEC_W-1:0]        req_vec;
  logic [VEC_W-1:0]        vec_mask;
  logic                    start;
  logic                    accepted;
  logic                    dropped;
  logic [IRQ_W-1:0]        irq_set;
  logic [IRQ_W-1:0]        irq_status;
  logic [IRQ_W-1:0]        irq_mask;
  logic                    wr_ctrl;
  logic                    wr_mask;
  logic                    wr_sw;
  logic                    rd_irq_status;

  // ---- register bus ----
  axil_reg_slave u_slave (
    .core_clk          (core_clk),
    .rst               (rst),
    .s_axi_ctl_awaddr  (s_axi_ctl_awaddr),
    .s_axi_ctl_awvalid (s_axi_ctl_awvalid),
    .s_axi_ctl_awready (s_axi_ctl_awready),
    .s_axi_ctl_wdata   (s_axi_ctl_wdata),
    .s_axi_ctl_wstrb   (s_axi_ctl_wstrb),
    .s_axi_ctl_wvalid  (s_axi_ctl_wvalid),
    .s_axi_ctl_wready  (s_axi_ctl_wready),
    .s_axi_ctl_bresp   (s_axi_ctl_bresp),
    .s_axi_ctl_bvalid  (s_axi_ctl_bvalid),
    .s_axi_ctl_bready  (s_axi_ctl_bready),
    .s_axi_ctl_araddr  (s_axi_ctl_araddr),
    .s_axi_ctl_arvalid (s_axi_ctl_arvalid),
    .s_axi_ctl_arready (s_axi_ctl_arready),
    .s_axi_ctl_rdata   (s_axi_ctl_rdata),
    .s_axi_ctl_rresp   (s_axi_ctl_rresp),
    .s_axi_ctl_rvalid  (s_axi_ctl_rvalid),
    .s_axi_ctl_rready  (s_axi_ctl_rready),
    .regs              (regs.bus)
  );

  // write decode; only byte lane 0 carries fields, so it alone gates writes
  assign wr_ctrl = regs.wr_en && (regs.wr_addr == REG_CTRL) && regs.wr_strb[0];
  assign wr_mask = regs.wr_en && (regs.wr_addr == REG_IRQ_MASK) && regs.wr_strb[0];
  assign wr_sw   = regs.wr_en && (regs.wr_addr == REG_SW_REQ) && regs.wr_strb[0];
  assign rd_irq_status = regs.rd_en && (regs.rd_addr == REG_IRQ_STATUS);

  // read-only registers answer a write with slverr
  always_comb begin
    regs.wr_ok = 1'b0;
    case (regs.wr_addr)
      REG_CTRL:     regs.wr_ok = 1'b1;
      REG_IRQ_MASK: regs.wr_ok = 1'b1;
      REG_SW_REQ:   regs.wr_ok = 1'b1;
      default:      regs.wr_ok = 1'b0;
    endcase
  end

  always_comb begin
    regs.rd_data = 32'h0000_0000;
    regs.rd_ok   = 1'b1;
    case (regs.rd_addr)
      REG_CTRL: begin
        regs.rd_data[CTRL_EN_BIT] = ctrl_en_reg;
      end
      REG_STATUS: begin
        regs.rd_data[STAT_MSI_BIT] = msi_en_reg;
        regs.rd_data[STAT_WIDTH_LSB +: VWID_W] = vwid_reg;
        regs.rd_data[STAT_BUSY_BIT] = (state_reg == ST_WAIT);
      end
      REG_IRQ_STATUS: begin
        regs.rd_data[IRQ_W-1:0] = irq_status;
      end
      REG_IRQ_MASK: begin
        regs.rd_data[IRQ_W-1:0] = irq_mask;
      end
      REG_COUNT: begin
        regs.rd_data[CNT_W-1:0] = msi_cnt_reg;
        regs.rd_data[CNT_LEG_LSB +: CNT_W] = leg_cnt_reg;
      end
      REG_LAST: begin
        regs.rd_data[VEC_W-1:0] = vec_reg;
        regs.rd_data[LAST_MODE_BIT] = mode_msi_reg;
      end
      REG_SW_REQ: begin
        regs.rd_data[VEC_W-1:0] = sw_vec_reg;
      end
      default: begin
        regs.rd_ok = 1'b0;
      end
    endcase
  end

  // ---- sticky events and interrupt ----
  always_comb begin
    // only the engine's two events feed the sticky status
    irq_set = '0;
    irq_set[IRQ_GRANT_BIT] = accepted;
    irq_set[IRQ_DROP_BIT]  = dropped;
  end

  irq_sticky u_irq (
    .core_clk   (core_clk),
    .rst        (rst),
    .event_set  (irq_set),
    .status_rd  (rd_irq_status),
    .mask_wr    (wr_mask),
    .mask_wdata (regs.wr_data[IRQ_W-1:0]),
    .status     (irq_status),
    .mask       (irq_mask),
    .irq        (irq)
  );

  // ---- request engine ----
  // the user pulse wins over a software request in the same cycle; the
  // loser is counted as dropped rather than queued, which keeps one
  // interrupt in flight and matches the one-outstanding user contract
  assign req_any = intx_msi_request || sw_req_reg;
  assign req_vec = intx_msi_request ? msi_vector_num : sw_vec_reg;

  // a vector outside the allocated range folds into it, as the host
  // only decodes the low bits it granted
  assign vec_mask = VEC_W'((32'h1 << vwid_reg) - 32'h1);

  assign start    = req_any && ctrl_en_reg && (state_reg == ST_IDLE);
  assign accepted = (state_reg == ST_WAIT) && core_int_accept;
  // requests arriving while busy or disabled are not stored
  assign dropped  = (req_any && !start) || (intx_msi_request && sw_req_reg);

  always_comb begin
    state_next    = state_reg;
    mode_msi_next = mode_msi_reg;
    vec_next      = vec_reg;
    grant_next    = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next    = ST_WAIT;
          // mode is frozen at the take, so an enable change cannot split it
          mode_msi_next = msi_en_reg;
          vec_next      = msi_en_reg ? (req_vec & vec_mask) : '0;
        end
      end
      ST_WAIT: begin
        if (core_int_accept) begin
          state_next = ST_IDLE;
          grant_next = 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ---- grant counters ----
  // counters wrap silently; software reads them as a running tally
  always_comb begin
    msi_cnt_next = msi_cnt_reg;
    leg_cnt_next = leg_cnt_reg;
    if (accepted) begin
      if (mode_msi_reg) begin
        msi_cnt_next = msi_cnt_reg + CNT_W'(1);
      end else begin
        leg_cnt_next = leg_cnt_reg + CNT_W'(1);
      end
    end
  end

  // ---- software controls and link status ----
  always_comb begin
    ctrl_en_next = wr_ctrl ? regs.wr_data[CTRL_EN_BIT] : ctrl_en_reg;
    sw_req_next  = wr_sw;
    sw_vec_next  = wr_sw ? regs.wr_data[VEC_W-1:0] : sw_vec_reg;
    // link status comes from logic on this clock, so one flop suffices
    msi_en_next  = core_msi_enabled;
    vwid_next    = core_msi_vec_alloc;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg    <= ST_IDLE;
      mode_msi_reg <= 1'b0;
      vec_reg      <= '0;
      grant_reg    <= 1'b0;
    end else begin
      state_reg    <= state_next;
      mode_msi_reg <= mode_msi_next;
      vec_reg      <= vec_next;
      grant_reg    <= grant_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      msi_cnt_reg  <= '0;
      leg_cnt_reg  <= '0;
    end else begin
      msi_cnt_reg  <= msi_cnt_next;
      leg_cnt_reg  <= leg_cnt_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_en_reg  <= CTRL_EN_RST;
      sw_req_reg   <= 1'b0;
      sw_vec_reg   <= '0;
      msi_en_reg   <= 1'b0;
      vwid_reg     <= '0;
    end else begin
      ctrl_en_reg  <= ctrl_en_next;
      sw_req_reg   <= sw_req_next;
      sw_vec_reg   <= sw_vec_next;
      msi_en_reg   <= msi_en_next;
      vwid_reg     <= vwid_next;
    end
  end

  // ---- outputs ----
  assign intx_msi_grant   = grant_reg;
  assign msi_enable       = msi_en_reg;
  assign msi_vector_width = vwid_reg;
  // valid comes straight from the state flop, so it cannot glitch
  assign core_int_valid   = (state_reg == ST_WAIT);
  assign core_int_is_msi  = mode_msi_reg;
  assign core_int_vector  = vec_reg;
  // legacy requests name the build-time pin; it stays static
  assign core_int_pin     = INTX_PIN;

endmodule : intx_msi_request_port
`default_nettype wire

// *** intx_msi_request_port_asserts.sv ***
// assertions on the user request port and link core side
`timescale 1ns/100ps
`default_nettype none
module intx_msi_request_port_asserts
  import intx_msi_pkg::*;
#(
  parameter logic [PIN_W-1:0] INTX_PIN = INTX_PIN_DEF
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // user port
  input  wire logic              intx_msi_request,
  input  wire logic [VEC_W-1:0]  msi_vector_num,
  input  wire logic              intx_msi_grant,
  input  wire logic              msi_enable,
  input  wire logic [VWID_W-1:0] msi_vector_width,
  // link core side
  input  wire logic              core_msi_enabled,
  input  wire logic [VWID_W-1:0] core_msi_vec_alloc,
  input  wire logic              core_int_valid,
  input  wire logic              core_int_is_msi,
  input  wire logic [VEC_W-1:0]  core_int_vector,
  input  wire logic [PIN_W-1:0]  core_int_pin,
  input  wire logic              core_int_accept
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // idle means no exchange open toward the link core
  sequence s_take_msi;
    intx_msi_request && !core_int_valid && msi_enable;
  endsequence
  sequence s_take_leg;
    intx_msi_request && !core_int_valid && !msi_enable;
  endsequence
  sequence s_accept;
    core_int_valid && core_int_accept;
  endsequence

  a_msi_start: assert property (s_take_msi |=> core_int_valid && core_int_is_msi
    && core_int_vector == ($past(msi_vector_num) & ~(5'h1F << $past(msi_vector_width))))
    else $error("message write not started");
  a_legacy_start: assert property (s_take_leg |=> core_int_valid && !core_int_is_msi
    && core_int_vector == '0 && core_int_pin == INTX_PIN)
    else $error("legacy interrupt not started");
  a_grant_follows: assert property (s_accept |=> intx_msi_grant)
    else $error("no grant after accept");
  a_grant_cause: assert property (intx_msi_grant |->
    $past(core_int_valid) && $past(core_int_accept))
    else $error("grant without accept");
  a_grant_single: assert property (intx_msi_grant |=> !intx_msi_grant)
    else $error("grant longer than one cycle");
  a_request_held: assert property (core_int_valid && !core_int_accept |=>
    core_int_valid && $stable(core_int_vector) && $stable(core_int_is_msi))
    else $error("open request changed");
  a_enable_tracks: assert property (!$past(rst) |-> msi_enable == $past(core_msi_enabled))
    else $error("enable status wrong");
  a_width_tracks: assert property (!$past(rst) |->
    msi_vector_width == $past(core_msi_vec_alloc))
    else $error("vector width wrong");
endmodule : intx_msi_request_port_asserts

bind intx_msi_request_port intx_msi_request_port_asserts #(.INTX_PIN(INTX_PIN)) u_asserts (.*);
`default_nettype wire

// *** intx_msi_request_port_tb.sv ***
// self-checking bench for the interrupt request port
`timescale 1ns/100ps
`default_nettype none
module intx_msi_request_port_tb
  import intx_msi_pkg::*;
;
  typedef struct packed {logic en; logic [2:0] alloc, dly; logic [4:0] vec, exp;} row_t;
  logic        core_clk, rst, s_axi_ctl_awvalid, s_axi_ctl_awready, s_axi_ctl_wvalid;
  logic        s_axi_ctl_wready, s_axi_ctl_bvalid, s_axi_ctl_bready, s_axi_ctl_arvalid;
  logic        s_axi_ctl_arready, s_axi_ctl_rvalid, s_axi_ctl_rready, intx_msi_request;
  logic        intx_msi_grant, msi_enable, core_msi_enabled, core_int_valid, core_int_is_msi;
  logic        core_int_accept, irq, go, rude;
  logic [31:0] s_axi_ctl_awaddr, s_axi_ctl_wdata, s_axi_ctl_araddr, s_axi_ctl_rdata;
  logic [3:0]  s_axi_ctl_wstrb;
  logic [1:0]  s_axi_ctl_bresp, s_axi_ctl_rresp, core_int_pin;
  logic [4:0]  msi_vector_num, core_int_vector, go_vec;
  logic [2:0]  msi_vector_width, core_msi_vec_alloc, dly, acc_cnt;
  int          fail_count, comparisons, cycles, grants;
  row_t        rows [5] = '{'{1'h1, 3'h0, 3'h2, 5'h1F, 5'h00}, '{1'h0, 3'h2, 3'h3, 5'h09, 5'h00},
                           '{1'h1, 3'h2, 3'h1, 5'h0D, 5'h01}, '{1'h0, 3'h0, 3'h7, 5'h1F, 5'h00},
                           '{1'h1, 3'h5, 3'h0, 5'h07, 5'h07}};

  intx_msi_request_port dut (.*);
  user_irq_source u_user (.*);

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  // link core stub: accepts dly+1 cycles after the request opens
  always @(posedge core_clk) begin
    if (rst || !core_int_valid || core_int_accept) begin
      acc_cnt <= 3'h0;
      core_int_accept <= 1'h0;
    end else begin
      acc_cnt <= acc_cnt + 3'h1;
      core_int_accept <= (acc_cnt == dly);
    end
    if (intx_msi_grant === 1'h1) grants++;
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    @(posedge core_clk);
    s_axi_ctl_awaddr <= a;
    s_axi_ctl_wdata <= d;
    s_axi_ctl_awvalid <= 1'h1;
    s_axi_ctl_wvalid <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge core_clk);
      if (s_axi_ctl_awvalid && s_axi_ctl_awready) begin
        aw_ok = 1'h1;
        s_axi_ctl_awvalid <= 1'h0;
      end
      if (s_axi_ctl_wvalid && s_axi_ctl_wready) begin
        w_ok = 1'h1;
        s_axi_ctl_wvalid <= 1'h0;
      end
    end
    s_axi_ctl_bready <= 1'h1;
    do @(posedge core_clk); while (s_axi_ctl_bvalid !== 1'h1);
    s_axi_ctl_bready <= 1'h0;
    chk(s_axi_ctl_bresp, er);
  endtask : wr

  task automatic rd(input logic [31:0] a, ed, input logic [1:0] er);
    @(posedge core_clk);
    s_axi_ctl_araddr <= a;
    s_axi_ctl_arvalid <= 1'h1;
    do @(posedge core_clk); while (s_axi_ctl_arready !== 1'h1);
    s_axi_ctl_arvalid <= 1'h0;
    s_axi_ctl_rready <= 1'h1;
    do @(posedge core_clk); while (s_axi_ctl_rvalid !== 1'h1);
    s_axi_ctl_rready <= 1'h0;
    chk(s_axi_ctl_rdata, ed);
    chk(s_axi_ctl_rresp, er);
  endtask : rd

  task automatic send(input logic [4:0] v, input logic r);
    @(posedge core_clk);
    go <= 1'h1;
    go_vec <= v;
    rude <= r;
    @(posedge core_clk);
    go <= 1'h0;
  endtask : send

  task automatic grant_seen();
    while (intx_msi_grant !== 1'h1) begin
      @(posedge core_clk);
      #1;
    end
    @(posedge core_clk);
    #1;
    chk(intx_msi_grant, 1'h0);
  endtask : grant_seen

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  initial begin
    {s_axi_ctl_awvalid, s_axi_ctl_wvalid, s_axi_ctl_bready, s_axi_ctl_arvalid} = 4'h0;
    {s_axi_ctl_rready, go, rude, core_msi_enabled} = 4'h0;
    {s_axi_ctl_awaddr, s_axi_ctl_wdata, s_axi_ctl_araddr} = '0;
    s_axi_ctl_wstrb = 4'hF;
    {go_vec, core_msi_vec_alloc, dly} = '0;
    rst = 1'h1;
    repeat (6) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    #1;
    chk({intx_msi_grant, core_int_valid, irq, msi_enable}, 4'h0);
    rd(REG_CTRL, 32'h1, RESP_OKAY);
    rd(REG_IRQ_MASK, 32'h0, RESP_OKAY);
    wr(REG_STATUS, 32'hF, RESP_SLVERR);
    rd(32'h0000_0040, 32'h0, RESP_SLVERR);
    foreach (rows[i]) begin
      @(posedge core_clk);
      core_msi_enabled <= rows[i].en;
      core_msi_vec_alloc <= rows[i].alloc;
      dly <= rows[i].dly;
      repeat (2) @(posedge core_clk);
      #1;
      chk(msi_enable, rows[i].en);
      chk(msi_vector_width, rows[i].alloc);
      send(rows[i].vec, 1'h0);
      @(posedge core_clk);
      #1;
      chk({core_int_valid, core_int_is_msi}, {1'h1, rows[i].en});
      chk({core_int_pin, core_int_vector}, {INTX_PIN_DEF, rows[i].exp});
      grant_seen();
    end
    rd(REG_STATUS, 32'h0000_000B, RESP_OKAY);
    rd(REG_COUNT, 32'h0002_0003, RESP_OKAY);
    rd(REG_IRQ_STATUS, 32'h1, RESP_OKAY);
    rd(REG_IRQ_STATUS, 32'h0, RESP_OKAY);
    // a second request while busy is dropped and only the drop bit reaches irq
    wr(REG_IRQ_MASK, 32'h2, RESP_OKAY);
    @(posedge core_clk);
    dly <= 3'h6;
    send(5'h03, 1'h0);
    send(5'h04, 1'h1);
    grant_seen();
    repeat (4) @(posedge core_clk);
    #1;
    chk(grants, 6);
    chk(irq, 1'h1);
    rd(REG_IRQ_STATUS, 32'h3, RESP_OKAY);
    #1;
    chk(irq, 1'h0);
    send(5'h05, 1'h0);
    grant_seen();
    chk(irq, 1'h0);
    rd(REG_IRQ_STATUS, 32'h1, RESP_OKAY);
    // software requests: refused while disabled, sent once enabled
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    wr(REG_SW_REQ, 32'h16, RESP_OKAY);
    repeat (3) @(posedge core_clk);
    #1;
    chk({core_int_valid, irq}, 2'h1);
    rd(REG_IRQ_STATUS, 32'h2, RESP_OKAY);
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    wr(REG_SW_REQ, 32'h16, RESP_OKAY);
    grant_seen();
    rd(REG_LAST, 32'h116, RESP_OKAY);
    // a reset in mid-run brings the registers back
    rst <= 1'h1;
    repeat (2) @(posedge core_clk);
    #1;
    chk({core_int_valid, irq, msi_enable, msi_vector_width}, 6'h0);
    @(posedge core_clk);
    rst <= 1'h0;
    rd(REG_IRQ_MASK, 32'h0, RESP_OKAY);
    rd(REG_COUNT, 32'h0, RESP_OKAY);
    wrap_up();
  end
endmodule : intx_msi_request_port_tb
`default_nettype wire

// *** irq_sticky.sv ***
// sticky event status with mask and one level interrupt
`timescale 1ns/100ps
`default_nettype none
module irq_sticky
  import intx_msi_pkg::*;
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // events and software access
  input  wire logic [IRQ_W-1:0] event_set,
  input  wire logic             status_rd,
  input  wire logic             mask_wr,
  input  wire logic [IRQ_W-1:0] mask_wdata,
  // state
  output logic [IRQ_W-1:0]      status,
  output logic [IRQ_W-1:0]      mask,
  output logic                  irq
);
  logic [IRQ_W-1:0] status_reg, status_next, mask_reg, mask_next;
  logic             irq_reg, irq_next;

  always_comb begin
    // a set in the same cycle as the clearing read survives the read
    status_next = (status_reg & {IRQ_W{!status_rd}}) | event_set;
    mask_next   = mask_wr ? mask_wdata : mask_reg;
    irq_next    = |(status_next & mask_next);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_reg <= '0;
      mask_reg   <= IRQ_MASK_RST;
      irq_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
      irq_reg    <= irq_next;
    end
  end

  assign status = status_reg;
  assign mask   = mask_reg;
  assign irq    = irq_reg;

endmodule : irq_sticky
`default_nettype wire

// *** reg_access_if.sv ***
// register access carrier between the bus slave and the register file
`timescale 1ns/100ps
`default_nettype none
interface reg_access_if;
  logic        wr_en;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic        rd_en;
  logic [31:0] rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;

  modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                input  wr_ok, rd_data, rd_ok);
  modport regs (input  wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                output wr_ok, rd_data, rd_ok);
endinterface : reg_access_if
`default_nettype wire

// *** user_irq_source.sv ***
// user logic model raising interrupt requests toward the port
`timescale 1ns/100ps
`default_nettype none
module user_irq_source
  import intx_msi_pkg::*;
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // bench control
  input  wire logic             go,
  input  wire logic             rude,
  input  wire logic [VEC_W-1:0] go_vec,
  // request port
  output logic                  intx_msi_request,
  output logic [VEC_W-1:0]      msi_vector_num,
  input  wire logic             intx_msi_grant
);
  logic waiting;

  // rude skips the wait for grant; only the busy-drop test sets it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      intx_msi_request <= 1'h0;
      msi_vector_num   <= '0;
      waiting          <= 1'h0;
    end else begin
      intx_msi_request <= go && (rude || !waiting || intx_msi_grant);
      if (go && (!waiting || intx_msi_grant)) begin
        msi_vector_num <= go_vec;
      end else if (!waiting) begin
        msi_vector_num <= ~msi_vector_num; // not held when idle, so keep it moving
      end
      waiting <= go || (waiting && !intx_msi_grant);
    end
  end
endmodule : user_irq_source
`default_nettype wire
